// ==== logic/cpu_addressing_mode_decode.sv ====
/*
 * effective-address generation and operand fetch for a small 8-bit core.
 * assumes program rom answers prog_addr combinationally within a byte cycle.
 */
// How it works
// - program, data and return-address spaces are kept apart.
// - effective address is where the operand is read or result written.
// - immediate operand is the byte after the opcode; no data access.
// - direct mode uses the next byte as data-space address.
// - short-direct opcode low bits pick one of 80..83.
// - pointer registers live at 80 and 81 in data space.
// - extended forms a 12-bit target from opcode nibble and next byte.
// - relative branch adds sign-extended five-bit offset only if taken.
// - bit set/clear: bit from opcode, address from next byte.
// - bit test branch is three bytes with sign-extended third byte offset.
// - tested bit is copied into carry, taken or not.
// - opcode bit 4 picks pointer; its contents are the address.
// - inherent uses only the opcode byte.
// - register/memory ops pair accumulator with memory; jumps use none.
// - increment, decrement and bit set/clear read, modify, write back.
// - opcode decode recognises the base operations across nine modes.
// - instructions take two, four or five byte cycles of osc/48.
// - jump/call: upper nibble is operation, lower nibble target high bits.
`timescale 1ns/1ps
module cpu_addressing_mode_decode
   import cpu_ea_pkg::*;
#(
   parameter int unsigned BYTE_DIV_P = BYTE_DIV
) (
   // clock, reset, enable
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             ce,
   // program space
   input  wire logic [7:0]       prog_data,
   output logic [PC_W-1:0]       prog_addr,
   // core state and return address
   output status_s               core_status,
   output logic [PC_W-1:0]       return_addr
);

   typedef enum logic [2:0] {
      S_OP, S_B2, S_B3, S_PW, S_PTR, S_DRD, S_EXE, S_PAD
   } state_e;

   // opcode decoding, used on fetch and for assertions
   function automatic mode_e mode_of(input logic [7:0] op);
      mode_e m;
      m = M_BAD;
      if (!op[7])                                m = M_REL;
      else if (op[7:5] == 3'h4)                  m = M_EXT;
      else if (op[7:2] == 6'h2a || op[7:2] == 6'h2b ||
               op[7:2] == 6'h2e || op[7:2] == 6'h2f) m = M_SHORT;
      else if (op == 8'hb4 || op == 8'hb5)       m = M_INH;
      else if (op[7:4] == 4'hc)                  m = M_BTB;
      else if (op[7:4] == 4'hd)                  m = M_BSC;
      else if (op[7:5] == 3'h7 && !op[3])        m = M_IND;
      else if (op[7:4] == 4'hf)                  m = M_DIR;
      else if (op == 8'he8 || (op >= 8'hea && op <= 8'hed)) m = M_IMM;
      return m;
   endfunction : mode_of

   function automatic op_e alu_of(input logic [2:0] f);
      op_e o;
      case (f)
         3'h0:    o = O_LDA;
         3'h1:    o = O_STA;
         3'h2:    o = O_ADD;
         3'h3:    o = O_SUB;
         3'h4:    o = O_CMP;
         3'h5:    o = O_AND;
         3'h6:    o = O_INC;
         default: o = O_DEC;
      endcase
      return o;
   endfunction : alu_of

   function automatic op_e op_of(input logic [7:0] op, input mode_e m);
      op_e o;
      o = O_NONE;
      case (m)
         M_REL:   o = O_BRA;
         M_EXT:   o = op[4] ? O_JMP : O_JSR;
         M_INH:   o = op[0] ? O_ROLA : O_INVERT_ACCUMULATOR;
         M_BTB:   o = op[POLARITY_BIT] ? O_BR1 : O_BR0;
         M_BSC:   o = op[POLARITY_BIT] ? O_BIT_SET_OP : O_BIT_CLEAR_OP;
         M_SHORT: begin
            // a8 inc, ac load, b8 dec, bc store
            case ({op[4], op[2]})
               2'h0:    o = O_INC;
               2'h1:    o = O_LDA;
               2'h2:    o = O_DEC;
               default: o = O_STA;
            endcase
         end
         M_IND, M_DIR, M_IMM: o = alu_of(op[2:0]);
         default: o = O_NONE;
      endcase
      return o;
   endfunction : op_of

   function automatic logic [2:0] cycles_of(input mode_e m);
      logic [2:0] c;
      case (m)
         M_REL, M_BAD: c = CYC_SHORT;
         M_IND, M_BTB: c = CYC_LONG;
         default:      c = CYC_STD;
      endcase
      return c;
   endfunction : cycles_of

   state_e            state;
   mode_e             mode;
   op_e               alu;
   logic [7:0]        opcode;
   logic [7:0]        ea;
   logic [7:0]        branch_ofs;
   logic [2:0]        cyc;
   logic [2:0]        target;
   logic [$clog2(BYTE_DIV_P+1)-1:0] div_cnt;
   logic [DATA_W-1:0] acc;
   logic              carry;
   logic              zero;
   logic              undefined;
   logic              step;
   logic              done;
   mode_e             dmode;
   op_e               dop;
   logic [7:0]        rdata;
   logic              ram_we;
   logic [7:0]        ram_wdata;
   logic [7:0]        bit_mask;
   logic [7:0]        operand;
   logic [8:0]        sum;
   logic              tested_bit;
   logic              rel_taken;
   logic [PC_W-1:0]   pc_inc;
   logic [PC_W-1:0]   next_pc;

   // byte-cycle divider: osc/4 then /12
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt <= '0;
      end else if (ce) begin
         div_cnt <= (div_cnt == ($bits(div_cnt))'(BYTE_DIV_P - 1)) ? '0 : div_cnt + 1'b1;
      end
   end

   // decode and datapath helpers
   always_comb begin
      step       = ce && (div_cnt == ($bits(div_cnt))'(BYTE_DIV_P - 1));
      dmode      = mode_of(prog_data);
      dop        = op_of(prog_data, dmode);
      done       = (cyc + 3'h1) >= target;
      bit_mask   = 8'h01 << opcode[2:0];
      tested_bit = |(rdata & bit_mask);
      operand    = (state == S_B2) ? prog_data : rdata;
      sum        = (alu == O_ADD) ? {1'b0, acc} + {1'b0, operand}
                                  : {1'b0, acc} - {1'b0, operand};
      case (prog_data[COND_LSB +: 2])
         2'h0:    rel_taken = !zero;
         2'h1:    rel_taken = zero;
         2'h2:    rel_taken = !carry;
         default: rel_taken = carry;
      endcase
   end

   // data-space write: only the execute step of store and read-modify-write
   always_comb begin
      ram_we = step && state == S_EXE && mode != M_BAD &&
               (alu == O_STA || alu == O_INC || alu == O_DEC ||
                alu == O_BIT_SET_OP || alu == O_BIT_CLEAR_OP);
      case (alu)
         O_INC:   ram_wdata = rdata + 8'h01;
         O_DEC:   ram_wdata = rdata - 8'h01;
         O_BIT_SET_OP:  ram_wdata = rdata | bit_mask;
         O_BIT_CLEAR_OP:  ram_wdata = rdata & ~bit_mask;
         default: ram_wdata = acc;
      endcase
   end

   // next program address
   always_comb begin
      pc_inc  = prog_addr + 12'h001;
      next_pc = prog_addr;
      case (state)
         S_OP: begin
            next_pc = pc_inc;
            if (dmode == M_REL && rel_taken) begin
               next_pc = pc_inc + {{(PC_W-REL_OFS_W){prog_data[4]}}, prog_data[4:0]};
            end
         end
         S_B2: begin
            next_pc = (mode == M_EXT) ? {opcode[3:0], prog_data} : pc_inc;
         end
         S_B3: next_pc = pc_inc;
         S_EXE: begin
            if (mode == M_BTB && (tested_bit == (alu == O_BR1))) begin
               next_pc = prog_addr + {{(PC_W-8){branch_ofs[7]}}, branch_ofs};
            end
         end
         default: next_pc = prog_addr;
      endcase
   end

   // program counter and return address
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prog_addr   <= PC_RESET;
         return_addr <= PC_RESET;
      end else if (step) begin
         prog_addr <= next_pc;
         if (state == S_B2 && alu == O_JSR) begin
            return_addr <= pc_inc;
         end
      end
   end

   // sequencing: opcode capture, mode, cycle count
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state  <= S_OP;
         mode   <= M_BAD;
         alu    <= O_NONE;
         opcode <= 8'h00;
         cyc    <= 3'h0;
         target <= CYC_SHORT;
      end else if (step) begin
         cyc <= cyc + 3'h1;
         case (state)
            S_OP: begin
               opcode <= prog_data;
               mode   <= dmode;
               alu    <= dop;
               cyc    <= 3'h1;
               target <= cycles_of(dmode);
               case (dmode)
                  M_INH, M_REL, M_BAD: state <= S_PAD;
                  M_SHORT:             state <= S_DRD;
                  M_IND:               state <= S_PW;
                  default:             state <= S_B2;
               endcase
            end
            S_B2: begin
               case (mode)
                  M_DIR, M_BSC: state <= S_DRD;
                  M_BTB:        state <= S_B3;
                  default:      state <= done ? S_OP : S_PAD;
               endcase
            end
            S_B3:    state <= S_EXE;
            S_PW:    state <= S_PTR;
            S_PTR:   state <= S_DRD;
            S_DRD:   state <= S_EXE;
            S_EXE:   state <= done ? S_OP : S_PAD;
            S_PAD:   state <= done ? S_OP : S_PAD;
            default: state <= S_OP;
         endcase
      end
   end

   // effective address and branch offset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ea         <= 8'h00;
         branch_ofs <= 8'h00;
      end else if (step) begin
         case (state)
            S_OP: begin
               if (dmode == M_SHORT) begin
                  ea <= SHORT_BASE | {6'h00, prog_data[1:0]};
               end else if (dmode == M_IND) begin
                  ea <= prog_data[IND_SEL_BIT] ? SECOND_PTR_ADDR : FIRST_PTR_ADDR;
               end
            end
            S_B2: begin
               if (mode == M_DIR || mode == M_BSC || mode == M_BTB) begin
                  ea <= prog_data;
               end
            end
            S_B3:  branch_ofs <= prog_data;
            S_PTR: ea <= rdata;
            default: ea <= ea;
         endcase
      end
   end

   // accumulator and flags
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc       <= ACC_RESET;
         carry     <= 1'b0;
         zero      <= 1'b0;
         undefined <= 1'b0;
      end else if (step) begin
         if (state == S_OP) begin
            undefined <= (dmode == M_BAD);
            if (dop == O_INVERT_ACCUMULATOR) begin
               acc  <= ~acc;
               zero <= (acc == 8'hff);
            end else if (dop == O_ROLA) begin
               acc   <= {acc[6:0], carry};
               carry <= acc[7];
            end
         end
         if ((state == S_B2 && mode == M_IMM) ||
             (state == S_EXE && mode != M_BTB && mode != M_BSC)) begin
            case (alu)
               O_LDA: begin
                  acc  <= operand;
                  zero <= (operand == 8'h00);
               end
               O_ADD, O_SUB: begin
                  acc   <= sum[7:0];
                  carry <= sum[8];
                  zero  <= (sum[7:0] == 8'h00);
               end
               O_CMP: begin
                  carry <= sum[8];
                  zero  <= (sum[7:0] == 8'h00);
               end
               O_AND: begin
                  acc  <= acc & operand;
                  zero <= ((acc & operand) == 8'h00);
               end
               O_INC, O_DEC: zero <= (ram_wdata == 8'h00);
               default: zero <= zero;
            endcase
         end
         if (state == S_EXE && mode == M_BTB) begin
            carry <= tested_bit;
         end
      end
   end

   // data space: ram, pointers and short-direct bytes
   data_space_ram #(
      .DEPTH (DSPACE_DEPTH),
      .W     (DATA_W)
   ) u_data_space (
      .clk     (clk),
      .reset_n (reset_n),
      .en      (step),
      .we      (ram_we),
      .addr    (ea),
      .wdata   (ram_wdata),
      .rdata   (rdata)
   );

   assign core_status = '{acc: acc, carry: carry, zero: zero,
                          undefined: undefined, effective_address: ea};

   // checks
   property p_imm_no_write;
      @(posedge clk) disable iff (!reset_n)
      (state == S_B2 && mode == M_IMM) |-> !ram_we;
   endproperty
   a_imm_no_write: assert property (p_imm_no_write) else $error("immediate wrote data space");

   property p_direct_ea;
      @(posedge clk) disable iff (!reset_n)
      (step && state == S_B2 && mode == M_DIR) |=> ea == $past(prog_data);
   endproperty
   a_direct_ea: assert property (p_direct_ea) else $error("direct address not taken");

   property p_short_ea;
      @(posedge clk) disable iff (!reset_n)
      (step && state == S_OP && dmode == M_SHORT) |=> ea == (SHORT_BASE | {6'h00, opcode[1:0]});
   endproperty
   a_short_ea: assert property (p_short_ea) else $error("short-direct address wrong");

   property p_ext_target;
      @(posedge clk) disable iff (!reset_n)
      (step && state == S_B2 && mode == M_EXT) |=> prog_addr == {opcode[3:0], $past(prog_data)};
   endproperty
   a_ext_target: assert property (p_ext_target) else $error("extended target wrong");

   property p_ind_ptr;
      @(posedge clk) disable iff (!reset_n)
      (step && state == S_OP && dmode == M_IND) |=> ea[7:1] == 7'h40 && ea[0] == opcode[IND_SEL_BIT];
   endproperty
   a_ind_ptr: assert property (p_ind_ptr) else $error("pointer select wrong");

   property p_btb_carry;
      @(posedge clk) disable iff (!reset_n)
      (step && state == S_EXE && mode == M_BTB) |=> carry == $past(tested_bit);
   endproperty
   a_btb_carry: assert property (p_btb_carry) else $error("carry not tested bit");

   property p_write_late;
      @(posedge clk) disable iff (!reset_n)
      ram_we |-> state == S_EXE && cyc >= 3'h2;
   endproperty
   a_write_late: assert property (p_write_late) else $error("write before read");

   property p_undef_quiet;
      @(posedge clk) disable iff (!reset_n)
      (step && state == S_OP && dmode == M_BAD) |=> !ram_we [*3];
   endproperty
   a_undef_quiet: assert property (p_undef_quiet) else $error("undefined op wrote");

   property p_length;
      @(posedge clk) disable iff (!reset_n)
      (step && state == S_OP && cyc != 3'h0) |-> cyc == CYC_SHORT || cyc == CYC_STD || cyc == CYC_LONG;
   endproperty
   a_length: assert property (p_length) else $error("bad instruction length");

   c_rel_taken: cover property (@(posedge clk) step && state == S_OP && dmode == M_REL && rel_taken);
   c_btb: cover property (@(posedge clk) step && state == S_EXE && mode == M_BTB);
   c_rmw: cover property (@(posedge clk) ram_we && alu == O_INC);
   c_jsr: cover property (@(posedge clk) step && state == S_B2 && alu == O_JSR);

endmodule : cpu_addressing_mode_decode

// ==== logic/cpu_ea_pkg.sv ====
/*
 * shared constants and types for the addressing-mode decoder core.
 * assumes a single byte-cycle clock domain and an 8-bit data space.
 */
package cpu_ea_pkg;

   // widths and spaces
   localparam int unsigned PC_W         = 12;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned DSPACE_DEPTH = 256;

   // data-space map: pointer registers and short-direct window
   localparam logic [7:0] FIRST_PTR_ADDR  = 8'h80;
   localparam logic [7:0] SECOND_PTR_ADDR = 8'h81;
   localparam logic [7:0] SHORT_BASE      = 8'h80;

   // byte-cycle division of the oscillator
   localparam int unsigned OSC_TO_PHASE_DIV  = 4;
   localparam int unsigned PHASE_TO_BYTE_DIV = 12;
   localparam int unsigned BYTE_DIV          = OSC_TO_PHASE_DIV * PHASE_TO_BYTE_DIV;

   // instruction lengths in byte cycles
   localparam logic [2:0] CYC_SHORT = 3'h2;
   localparam logic [2:0] CYC_STD   = 3'h4;
   localparam logic [2:0] CYC_LONG  = 3'h5;

   // reset values
   localparam logic [PC_W-1:0]   PC_RESET  = 12'h000;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

   // opcode field positions
   localparam int unsigned IND_SEL_BIT = 4;
   localparam int unsigned POLARITY_BIT = 3;
   localparam int unsigned COND_LSB    = 5;
   localparam int unsigned REL_OFS_W   = 5;

   typedef enum logic [3:0] {
      M_INH, M_REL, M_SHORT, M_IND, M_IMM, M_DIR, M_EXT, M_BSC, M_BTB, M_BAD
   } mode_e;

   typedef enum logic [4:0] {
      O_LDA, O_STA, O_ADD, O_SUB, O_CMP, O_AND, O_INC, O_DEC, O_INVERT_ACCUMULATOR, O_ROLA,
      O_JMP, O_JSR, O_BIT_SET_OP, O_BIT_CLEAR_OP, O_BR1, O_BR0, O_BRA, O_NONE
   } op_e;

   typedef struct packed {
      logic [DATA_W-1:0] acc;
      logic              carry;
      logic              zero;
      logic              undefined;
      logic [DATA_W-1:0] effective_address;
   } status_s;

endpackage : cpu_ea_pkg

// ==== logic/data_space_ram.sv ====
/*
 * data-space memory: synchronous write, registered read.
 * assumes en marks the byte-cycle step; read data follow one step later.
 */
`timescale 1ns/1ps
module data_space_ram #(
   parameter int unsigned DEPTH = 256,
   parameter int unsigned W     = 8,
   parameter int unsigned AW    = $clog2(DEPTH)
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic          en,
   // access
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [W-1:0]  wdata,
   output logic [W-1:0]       rdata
);

   logic [W-1:0] mem [DEPTH];

   // storage write
   always_ff @(posedge clk) begin
      if (en && we) begin
         mem[addr] <= wdata;
      end
   end

   // registered read port
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= '0;
      end else if (en) begin
         rdata <= mem[addr];
      end
   end

endmodule : data_space_ram

// ==== testbench/cpu_addressing_mode_decode_test.sv ====
/*
 * self-checking bench for the addressing-mode decoder: three short programs with checkpoints.
 * assumes the rom model answers combinationally and that BYTE_DIV_P is set to 1.
 */
`timescale 1ns/1ps
module cpu_addressing_mode_decode_test;
   import cpu_ea_pkg::*;

   // checkpoint: expected state when prog_addr last shows addr
   typedef struct {
      logic [PC_W-1:0] addr;
      logic [7:0]      acc;
      logic [7:0]      ea;
      logic            c;
      logic            u;
      logic [PC_W-1:0] ret;
      logic [4:0]      m;
   } note_s;

   logic            clk;
   logic            reset_n;
   logic            ce;
   logic [7:0]      prog_data;
   logic [PC_W-1:0] prog_addr;
   status_s         core_status;
   logic [PC_W-1:0] return_addr;
   note_s           q[$];
   note_s           e;
   logic [7:0]      v;
   logic [PC_W-1:0] last_addr;
   logic [PC_W-1:0] last_ret;
   status_s         last_status;
   int              seed = 82;
   int              fail_count = 0;
   int              n_checks = 0;
   int              cyc = 0;

   cpu_addressing_mode_decode #(.BYTE_DIV_P(1)) u_dut (
      .clk         (clk),
      .reset_n     (reset_n),
      .ce          (ce),
      .prog_data   (prog_data),
      .prog_addr   (prog_addr),
      .core_status (core_status),
      .return_addr (return_addr)
   );

   prog_rom_model u_rom (
      .addr (prog_addr),
      .data (prog_data)
   );

   // free-running clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // hold reset and fill the rom with an undefined opcode
   task automatic start;
      @(negedge clk);
      reset_n = 1'b0;
      for (int i = 0; i < (1 << PC_W); i++) begin
         u_rom.mem[i] = 8'ha0;
      end
   endtask : start

   // n bytes, first byte in the top of the low n bytes of b
   task automatic put(input logic [PC_W-1:0] a, input logic [63:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         u_rom.mem[int'(a) + i] = b[8*(n-1-i) +: 8];
      end
   endtask : put

   task automatic note(input logic [PC_W-1:0] a, input logic [7:0] acc, input logic [7:0] ea,
                       input logic c, input logic u, input logic [PC_W-1:0] ret, input logic [4:0] m);
      note_s n;
      n = '{a, acc, ea, c, u, ret, m};
      q.push_back(n);
   endtask : note

   // release reset and wait, bounded, for every checkpoint to be reached
   task automatic run(input string name);
      int w;
      @(negedge clk);
      reset_n = 1'b1;
      for (w = 0; w < 400 && q.size() != 0; w++) begin
         @(negedge clk);
      end
      if (q.size() != 0) begin
         fail_count++;
         $display("[FAIL] %s checkpoint at %h never reached", name, q[0].addr);
         q.delete();
      end
      $display("test %s done", name);
   endtask : run

   // random clock enable stalls the byte cycles
   always @(negedge clk) begin
      ce <= ($random(seed) & 3) != 0;
   end

   // compare the state held just before the opcode at the checkpoint is fetched
   always @(negedge clk) begin
      if (reset_n && q.size() != 0 && prog_addr !== last_addr && last_addr === q[0].addr) begin
         e = q.pop_front();
         if (e.m[0]) check("acc", 16'(last_status.acc), 16'(e.acc));
         if (e.m[1]) check("effective_address", 16'(last_status.effective_address), 16'(e.ea));
         if (e.m[2]) check("carry", 16'(last_status.carry), 16'(e.c));
         if (e.m[3]) check("undefined", 16'(last_status.undefined), 16'(e.u));
         if (e.m[4]) check("return_addr", 16'(last_ret), 16'(e.ret));
      end
      last_addr   = prog_addr;
      last_status = core_status;
      last_ret    = return_addr;
   end

   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   // main sequence
   initial begin
      reset_n = 1'b0;
      ce = 1'b0;
      start();
      repeat (5) @(negedge clk);
      check("prog_addr at reset", 16'(prog_addr), 16'(PC_RESET));
      check("acc at reset", 16'(core_status.acc), 16'(ACC_RESET));
      // immediate, direct, short-direct and indirect through the second pointer
      v = 8'($random(seed)) | 8'h01;
      start();
      put(12'h000, {8'he8, v, 48'hf9_40_e8_00_f8_40}, 8);
      put(12'h008, 64'hbc_e8_40_bd_e8_00_f0_ac, 8);
      put(12'h010, 64'h90_10, 2);
      note(12'h00f, v, 8'h40, 1'b0, 1'b0, 12'h000, 5'b00011);
      note(12'h010, v, 8'h80, 1'b0, 1'b0, 12'h000, 5'b00011);
      run("addressing");
      // read-modify-write and bit test branches, taken and not taken
      start();
      put(12'h000, 64'he8_0f_f9_41_df_41_d0_41, 8);
      put(12'h008, 64'hff_41_cf_41_02_e8_11_c9, 8);
      put(12'h010, 64'h41_70_f8_41_90_14, 6);
      note(12'h00f, 8'h0f, 8'h41, 1'b1, 1'b0, 12'h000, 5'b00111);
      note(12'h012, 8'h0f, 8'h41, 1'b0, 1'b0, 12'h000, 5'b00101);
      note(12'h014, 8'h8d, 8'h41, 1'b0, 1'b0, 12'h000, 5'b00011);
      run("bit_ops");
      // relative, extended jump and call, undefined opcode, wrap of the counter
      start();
      put(12'h000, 64'he8_00_23_b4_90_04_9c_00, 8);
      put(12'hc00, 64'h8f_f0, 2);
      put(12'hff0, 64'ha0_9f_ff, 3);
      put(12'hfff, 64'h23, 1);
      note(12'h006, 8'h00, 8'h00, 1'b0, 1'b0, 12'h000, 5'b00001);
      note(12'hff0, 8'h00, 8'h00, 1'b0, 1'b0, 12'hc02, 5'b10000);
      note(12'hff1, 8'h00, 8'h00, 1'b0, 1'b1, 12'h000, 5'b01000);
      note(12'h004, 8'hff, 8'h00, 1'b0, 1'b0, 12'h000, 5'b01001);
      run("control_flow");
      report_and_stop();
   end

endmodule : cpu_addressing_mode_decode_test

// ==== testbench/prog_rom_model.sv ====
/*
 * program rom model: a 4096-byte image read combinationally at the program address.
 * assumes the bench loads the image only while the core is held in reset.
 */
`timescale 1ns/1ps
module prog_rom_model
   import cpu_ea_pkg::*;
(
   // program bus
   input  wire logic [PC_W-1:0] addr,
   output logic [7:0]           data
);

   // program image only; there is no path from here into data space
   logic [7:0] mem [0:(1<<PC_W)-1];

   // addressed byte, always driven; the rom has no select
   assign data = mem[addr];

endmodule : prog_rom_model
